/* logic/rpm_pkg.sv */
/*
  Constants, field layouts and carrier types for the prescaled
  modulo tick counter.
  Assumes a 32-bit AHB-Lite register bus; each 8-bit register sits in
  the low byte of one aligned word at four times its register index.
*/
`default_nettype none

package rpm_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_MATCH_CTRL = 16'h306A;
  localparam logic [15:0] IDX_SRC_PS = 16'h306B;
  localparam logic [15:0] IDX_MOD_HI = 16'h306C;
  localparam logic [15:0] IDX_MOD_LO = 16'h306D;
  localparam logic [15:0] IDX_CNT_HI = 16'h306E;
  localparam logic [15:0] IDX_CNT_LO = 16'h306F;
  localparam int unsigned ADDR_SHIFT = 2;
  localparam logic [15:0] ADDR_MATCH_CTRL = IDX_MATCH_CTRL << ADDR_SHIFT;
  localparam logic [15:0] ADDR_SRC_PS = IDX_SRC_PS << ADDR_SHIFT;
  localparam logic [15:0] ADDR_MOD_HI = IDX_MOD_HI << ADDR_SHIFT;
  localparam logic [15:0] ADDR_MOD_LO = IDX_MOD_LO << ADDR_SHIFT;
  localparam logic [15:0] ADDR_CNT_HI = IDX_CNT_HI << ADDR_SHIFT;
  localparam logic [15:0] ADDR_CNT_LO = IDX_CNT_LO << ADDR_SHIFT;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned IE_BIT = 6;
  localparam int unsigned SRC_MSB = 7;
  localparam int unsigned SRC_LSB = 6;
  localparam int unsigned PS_MSB = 2;
  localparam int unsigned PS_LSB = 0;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_EXT_OSC = 2'h0;
  localparam logic [1:0] SRC_LOW_PWR = 2'h1;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [2:0] PS_OFF = 3'h0;
  localparam logic [2:0] PS_RST = 3'h0;
  localparam logic [2:0] PS_DEC_LO = 3'h6;
  localparam logic [2:0] PS_DEC_HI = 3'h7;
  localparam logic [7:0] MOD_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ---------------------------------------------------------------
  // Divide ratios
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DIV_W = 12;
  localparam int unsigned DIV_BIN_BASE = 1;
  localparam int unsigned DIV_HI_BASE = 128;
  localparam int unsigned DIV_DEC_LO = 100;
  localparam int unsigned DIV_DEC_HI = 1000;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
  } rpm_ahb_req_t;

  typedef struct packed {
    logic [1:0] src;
    logic [2:0] ps;
  } rpm_ctrl_t;

  // Last prescaler count (ratio minus one) for a source and code
  function automatic logic [DIV_W-1:0] rpm_div_last(
    input logic src_lsb,
    input logic [2:0] ps
  );
    logic [DIV_W-1:0] r;
    r = '0;
    if (ps == PS_OFF) begin
      r = '0;
    end else if (!src_lsb) begin
      r = DIV_W'((DIV_BIN_BASE << (ps - 3'h1)) - 1);
    end else if (ps == PS_DEC_LO) begin
      r = DIV_W'(DIV_DEC_LO - 1);
    end else if (ps == PS_DEC_HI) begin
      r = DIV_W'(DIV_DEC_HI - 1);
    end else begin
      r = DIV_W'((DIV_HI_BASE << (ps - 3'h1)) - 1);
    end
    return r;
  endfunction : rpm_div_last

endpackage : rpm_pkg

`default_nettype wire

/* logic/rpm_edge_sync.sv */
/*
  Two-flop synchroniser with rising edge detection for a slow clock
  arriving from outside the bus clock domain.
  Assumes the incoming clock is well below half the bus clock rate.
*/
`timescale 1ns/10ps
`default_nettype none

module rpm_edge_sync
  import rpm_pkg::*;
(
  input wire logic clk_sys, // Bus clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic async_in, // Foreign clock level
  output var logic rise_q // One-cycle pulse per rising edge
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // ---------------------------------------------------------------
  // Synchroniser and edge detector
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      rise_q <= sync_q & ~prev_q;
    end
  end

endmodule : rpm_edge_sync

`default_nettype wire

/* logic/rpm_prescaler.sv */
/*
  Binary and decimal prescaler driven by a per-cycle source enable.
  Assumes source enables are already in the bus clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module rpm_prescaler
  import rpm_pkg::*;
#(
  parameter int unsigned WIDTH = DIV_W
)
(
  input wire logic clk_sys, // Bus clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic src_tick, // One source edge this cycle
  input wire rpm_ctrl_t ctrl, // Source and prescaler codes
  input wire logic clear, // Return prescaler to zero
  output var logic tick_q // One-cycle pulse per output period
);

  generate
    if (WIDTH < 11 || WIDTH > DIV_W) begin : g_bad_width
      $error("prescaler width cannot hold the ratios");
    end
  endgenerate

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] last;
  logic off;

  // ---------------------------------------------------------------
  // Ratio selection
  // ---------------------------------------------------------------
  assign last = WIDTH'(rpm_div_last(ctrl.src[0], ctrl.ps));
  assign off = (ctrl.ps == PS_OFF);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (clear || off) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (src_tick && cnt_q >= last) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else if (src_tick) begin
      cnt_q <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
    end
  end

endmodule : rpm_prescaler

`default_nettype wire

/* logic/rpm_top.sv */
/*
  Prescaled 16-bit modulo tick counter with an AHB-Lite register slave.
  Assumes one AHB-Lite master, word transfers only, and slow external
  and low-power clocks that are asynchronous to clk_sys.
*/
// The implementer's own choice: the AHB-Lite slave port.
// Functional notes
// - Source code 00 external oscillator, 01 low-power clock, 1x bus clock.
// - Writing a new source code clears prescaler and count.
// - Reset selects source code 00.
// - Prescaler code 000 stops; with source bit0 low divide 1 to 64.
// - With source bit0 high, codes 001 to 101 divide 128 to 2048.
// - With source bit0 high, code 110 divides 100, 111 divides 1000.
// - Writing a new prescaler code clears prescaler and count.
// - Reset clears the prescaler code, so counting stops.
// - Control bits 5 to 3 read zero and ignore writes.
// - On count equal to modulo, count returns to zero, flag sets.
// - Modulo zero sets the flag on every prescaler output tick.
// - Reset clears both modulo bytes.
// - Reading count low freezes count high for a consistent pair.
// - Count bytes are read-only; writes leave count alone.
// - Reset clears count; unchanged codes on write keep count.
// - Count advances once per prescaler period, wraps and continues.
// - Flag sets on the step from modulo value to zero.
// - Writing one clears the flag; writing zero does nothing.
// - Interrupt request is driven while flag and enable are set.
`timescale 1ns/10ps
`default_nettype none

module rpm_top
  import rpm_pkg::*;
(
  input wire logic clk_sys, // Bus clock, 100 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic ext_osc_clk, // External oscillator clock
  input wire logic lp_osc_clk, // Low-power oscillator clock
  input wire rpm_ahb_req_t ahb_req, // AHB-Lite address phase
  input wire logic [31:0] hwdata, // AHB-Lite write data
  input wire logic hready, // AHB-Lite bus ready
  output var logic [31:0] hrdata, // AHB-Lite read data
  output var logic hreadyout, // AHB-Lite slave ready
  output var logic hresp, // AHB-Lite response, always OKAY
  output var logic match_irq // Match interrupt request
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The byte lock and the read mux assume a two-byte count
  generate
    if (CNT_W != 16) begin : g_bad_cnt
      $error("tick count must be sixteen bits wide");
    end
    if (DIV_W < 11) begin : g_bad_div
      $error("prescaler count too narrow for the largest ratio");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Address decode helper
  // ---------------------------------------------------------------
  function automatic logic rpm_hit(
    input logic [15:0] addr,
    input logic [15:0] reg_addr
  );
    return addr == reg_addr;
  endfunction : rpm_hit

  // ---------------------------------------------------------------
  // Source edges
  // ---------------------------------------------------------------
  logic ext_rise;
  logic lp_rise;
  logic src_tick;

  rpm_edge_sync u_ext_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(ext_osc_clk),
    .rise_q(ext_rise)
  );

  rpm_edge_sync u_lp_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(lp_osc_clk),
    .rise_q(lp_rise)
  );

  rpm_ctrl_t ctrl_q;
  rpm_ctrl_t ctrl_d;

  // Bus source counts every cycle, foreign sources only on synced edges
  assign src_tick = (ctrl_q.src == SRC_EXT_OSC) ? ext_rise :
                    (ctrl_q.src == SRC_LOW_PWR) ? lp_rise :
                    1'b1;

  // ---------------------------------------------------------------
  // Bus phases
  // ---------------------------------------------------------------
  logic addr_ph;
  logic rd_ph;
  logic wr_start;
  logic wr_pend_q;
  logic [15:0] wr_addr_q;
  logic [15:0] rd_addr;

  assign addr_ph = ahb_req.hsel && hready
                   && (ahb_req.htrans == HTRANS_NONSEQ);
  assign wr_start = addr_ph && ahb_req.hwrite;
  assign rd_ph = addr_ph && !ahb_req.hwrite;
  assign rd_addr = ahb_req.haddr[15:0];

  // One wait state on writes so a following read sees the new value
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      hreadyout <= 1'b1;
    end else if (wr_start) begin
      wr_pend_q <= 1'b1;
      wr_addr_q <= rd_addr;
      hreadyout <= 1'b0;
    end else begin
      wr_pend_q <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Write strobes
  // ---------------------------------------------------------------
  logic wr_match;
  logic wr_ctrl;
  logic wr_mod_hi;
  logic wr_mod_lo;
  logic cfg_change;

  assign wr_match = wr_pend_q && rpm_hit(wr_addr_q, ADDR_MATCH_CTRL);
  assign wr_ctrl = wr_pend_q && rpm_hit(wr_addr_q, ADDR_SRC_PS);
  assign wr_mod_hi = wr_pend_q && rpm_hit(wr_addr_q, ADDR_MOD_HI);
  assign wr_mod_lo = wr_pend_q && rpm_hit(wr_addr_q, ADDR_MOD_LO);
  assign ctrl_d.src = wr_ctrl ? hwdata[SRC_MSB:SRC_LSB] : ctrl_q.src;
  assign ctrl_d.ps = wr_ctrl ? hwdata[PS_MSB:PS_LSB] : ctrl_q.ps;
  // Rewriting the same codes must not disturb a running count
  assign cfg_change = wr_ctrl && (ctrl_d != ctrl_q);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q.src <= SRC_RST;
      ctrl_q.ps <= PS_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic ps_tick;

  rpm_prescaler #(
    .WIDTH(DIV_W)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .src_tick(src_tick),
    .ctrl(ctrl_q),
    .clear(cfg_change),
    .tick_q(ps_tick)
  );

  // ---------------------------------------------------------------
  // Modulo and count
  // ---------------------------------------------------------------
  logic [7:0] mod_hi_q;
  logic [7:0] mod_lo_q;
  logic [15:0] mod_act_q;
  logic [15:0] tick_count_q;
  logic wrap;
  logic mod_load;

  // A code change wins over a wrap in the same cycle
  assign wrap = ps_tick && !cfg_change
                && (tick_count_q == mod_act_q);
  // Modulo is taken on each wrap, and freely while the prescaler is off
  assign mod_load = wrap || (ctrl_q.ps == PS_OFF) || cfg_change;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mod_hi_q <= MOD_RST;
      mod_lo_q <= MOD_RST;
    end else begin
      if (wr_mod_hi) begin
        mod_hi_q <= hwdata[7:0];
      end
      if (wr_mod_lo) begin
        mod_lo_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mod_act_q <= {MOD_RST, MOD_RST};
    end else if (mod_load) begin
      mod_act_q <= {mod_hi_q, mod_lo_q};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_count_q <= CNT_RST;
    end else if (cfg_change) begin
      tick_count_q <= CNT_RST;
    end else if (wrap) begin
      tick_count_q <= CNT_RST;
    end else if (ps_tick) begin
      tick_count_q <= tick_count_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Match flag and interrupt
  // ---------------------------------------------------------------
  logic match_flag_q;
  logic match_irq_enable_q;
  logic flag_clr;

  assign flag_clr = wr_match && hwdata[FLAG_BIT];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      match_flag_q <= 1'b0;
      match_irq_enable_q <= 1'b0;
      match_irq <= 1'b0;
    end else begin
      // A wrap in the clearing cycle keeps the flag set
      match_flag_q <= wrap || (match_flag_q && !flag_clr);
      if (wr_match) begin
        match_irq_enable_q <= hwdata[IE_BIT];
      end
      match_irq <= match_flag_q && match_irq_enable_q;
    end
  end

  // ---------------------------------------------------------------
  // Read path and byte lock
  // ---------------------------------------------------------------
  logic lock_q;
  logic [7:0] cnt_hi_hold_q;
  logic rd_cnt_lo;
  logic rd_cnt_hi;
  logic [7:0] cnt_hi_view;
  logic [7:0] rd_byte;

  // Holding the high byte makes the two byte reads one coherent value
  assign rd_cnt_lo = rd_ph && rpm_hit(rd_addr, ADDR_CNT_LO);
  assign rd_cnt_hi = rd_ph && rpm_hit(rd_addr, ADDR_CNT_HI);
  assign cnt_hi_view = lock_q ? cnt_hi_hold_q : tick_count_q[15:8];
  assign rd_byte =
    rpm_hit(rd_addr, ADDR_MATCH_CTRL) ?
      {match_flag_q, match_irq_enable_q, 6'h00} :
    rpm_hit(rd_addr, ADDR_SRC_PS) ?
      {ctrl_q.src, 3'h0, ctrl_q.ps} :
    rpm_hit(rd_addr, ADDR_MOD_HI) ? mod_hi_q :
    rpm_hit(rd_addr, ADDR_MOD_LO) ? mod_lo_q :
    rpm_hit(rd_addr, ADDR_CNT_HI) ? cnt_hi_view :
    rpm_hit(rd_addr, ADDR_CNT_LO) ? tick_count_q[7:0] :
    8'h00;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lock_q <= 1'b0;
      cnt_hi_hold_q <= 8'h00;
    end else if (rd_cnt_lo) begin
      lock_q <= 1'b1;
      cnt_hi_hold_q <= tick_count_q[15:8];
    end else if (rd_cnt_hi) begin
      lock_q <= 1'b0;
    end
  end

  // Read data is registered at the address edge, so reads need no wait
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_ph) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule : rpm_top

`default_nettype wire

/* test/rpm_top_asserts.sv */
/*
  Checker for the tick counter register slave.
  Bound to rpm_top from the testbench top; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none

module rpm_top_asserts
  import rpm_pkg::*;
(
  input wire logic clk_sys, // Bus clock
  input wire logic nrst, // Reset, active low
  input wire rpm_ahb_req_t ahb_req, // Address phase
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic match_irq // Interrupt request
);
  // ---------------------------------------------------------------
  // Transfer decode and enable mirror
  // ---------------------------------------------------------------
  logic take, wr_take, rd_take, wp_q, ie_q;
  logic [15:0] wa_q;
  assign take = ahb_req.hsel && ahb_req.htrans == HTRANS_NONSEQ && hready;
  assign wr_take = take && ahb_req.hwrite;
  assign rd_take = take && !ahb_req.hwrite;

  // Enable copy taken at the edge that applies a write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_q <= 1'b0;
      wa_q <= 16'h0000;
      ie_q <= 1'b0;
    end else begin
      wp_q <= wr_take;
      wa_q <= ahb_req.haddr[15:0];
      if (wp_q && wa_q == ADDR_MATCH_CTRL) begin
        ie_q <= hwdata[IE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_wait_one;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence s_rd_ctrl;
    rd_take && ahb_req.haddr[15:0] == ADDR_SRC_PS;
  endsequence

  a_write_wait: assert property (wr_take |=> s_wait_one)
    else $error("write wait state not exactly one cycle");
  a_read_nowait: assert property (rd_take |=> hreadyout)
    else $error("read inserted a wait state");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_ctrl_rsvd: assert property (s_rd_ctrl |=> hrdata[5:3] == 3'h0)
    else $error("control reserved bits read nonzero");
  a_unmapped_zero: assert property (
    rd_take && ahb_req.haddr[15:0] > ADDR_CNT_LO |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_enable: assert property (match_irq |-> ie_q || $past(ie_q))
    else $error("interrupt request without enable");
  a_reset_idle: assert property (
    $rose(nrst) |-> hreadyout && !match_irq && hrdata == 32'h0)
    else $error("outputs not idle after reset");

endmodule : rpm_top_asserts

`default_nettype wire

/* test/rpm_top_test.sv */
/*
  Self-checking testbench for rpm_top, driving AHB-Lite single word
  transfers and free-running external and low-power clocks.
  Assumes hready is fed back from hreadyout (single slave).
*/
`timescale 1ns/10ps
`default_nettype none

module rpm_top_test
  import rpm_pkg::*;
;
  logic clk_sys, nrst, hready, hreadyout, hresp;
  logic ext_osc_clk = 1'b0;
  logic lp_osc_clk = 1'b0;
  logic match_irq;
  rpm_ahb_req_t ahb_req;
  logic [31:0] hwdata, hrdata, a, b;
  logic [15:0] cur, prv;
  int num_errors, cmp_count;
  int ec = 0;
  int lc = 0;
  assign hready = hreadyout;

  rpm_top i_rpm_top (.clk_sys(clk_sys), .nrst(nrst),
    .ext_osc_clk(ext_osc_clk), .lp_osc_clk(lp_osc_clk), .ahb_req(ahb_req),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .match_irq(match_irq));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Oscillators: period 20 and 50 bus cycles
  always @(posedge clk_sys) begin
    ec <= (ec == 9) ? 0 : ec + 1;
    lc <= (lc == 24) ? 0 : lc + 1;
    if (ec == 9) ext_osc_clk <= ~ext_osc_clk;
    if (lc == 24) lp_osc_clk <= ~lp_osc_clk;
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask : wait_rdy

  task automatic xfer(input logic [15:0] ad, input logic w,
                      input logic [7:0] wd, output logic [31:0] rd);
    ahb_req <= '{hsel: 1'b1, htrans: HTRANS_NONSEQ,
                 haddr: {16'h0000, ad}, hwrite: w, hsize: 3'h2};
    wait_rdy();
    ahb_req <= '0;
    hwdata <= {24'h000000, wd};
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [15:0] ad, input logic [7:0] wd);
    logic [31:0] d;
    xfer(ad, 1'b1, wd, d);
  endtask : wr

  task automatic rdc(input logic [15:0] ad, input logic [31:0] exp);
    logic [31:0] d;
    xfer(ad, 1'b0, 8'h00, d);
    chk(d, exp);
  endtask : rdc

  // Count advance over four output periods, sampled edges apart exactly
  task automatic meas(input logic [7:0] code, input int per);
    wr(ADDR_SRC_PS, code);
    xfer(ADDR_CNT_LO, 1'b0, 8'h00, a);
    repeat (4 * per - 2) @(posedge clk_sys);
    xfer(ADDR_CNT_LO, 1'b0, 8'h00, b);
    chk({24'h000000, b[7:0] - a[7:0]}, 32'h4);
  endtask : meas

  function automatic int div_of(logic s0, logic [2:0] p);
    if (!s0) return 1 << (p - 1);
    if (p == 3'h6) return 100;
    if (p == 3'h7) return 1000;
    return 128 << (p - 1);
  endfunction : div_of

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    ahb_req = '0;
    hwdata = 32'h0;
    num_errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdc(ADDR_MATCH_CTRL + 16'(4 * i), 32'h0);
    end
    wr(ADDR_SRC_PS, 8'hFF);
    rdc(ADDR_SRC_PS, 32'hC7);
    wr(ADDR_SRC_PS, 8'h00);
    wr(ADDR_MOD_HI, 8'hFF);
    rdc(ADDR_MOD_HI, 32'hFF);
    wr(ADDR_MOD_LO, 8'hFF);
    rdc(ADDR_MOD_LO, 32'hFF);
    for (int s = 2; s < 4; s++) begin
      for (int p = 1; p < 8; p++) begin
        meas({s[1:0], 3'h0, p[2:0]}, div_of(s[0], p[2:0]));
      end
    end
    meas(8'h01, 20);
    meas(8'h46, 5000);
    wr(ADDR_SRC_PS, 8'h81);
    prv = 16'h0000;
    for (int i = 0; i < 130; i++) begin
      xfer(ADDR_CNT_LO, 1'b0, 8'h00, a);
      xfer(ADDR_CNT_HI, 1'b0, 8'h00, b);
      cur = {b[7:0], a[7:0]};
      if (i > 0) chk({16'h0000, cur - prv}, 32'h4);
      prv = cur;
    end
    wr(ADDR_SRC_PS, 8'h87);
    rdc(ADDR_CNT_LO, 32'h0);
    repeat (300) @(posedge clk_sys);
    xfer(ADDR_CNT_LO, 1'b0, 8'h00, a);
    wr(ADDR_SRC_PS, 8'h87);
    xfer(ADDR_CNT_LO, 1'b0, 8'h00, b);
    chk({31'h0, b[7:0] >= a[7:0] && a[7:0] != 8'h00}, 32'h1);
    wr(ADDR_SRC_PS, 8'hC7);
    rdc(ADDR_CNT_LO, 32'h0);
    wr(ADDR_SRC_PS, 8'h80);
    wr(ADDR_CNT_LO, 8'h55);
    wr(ADDR_CNT_HI, 8'h55);
    rdc(ADDR_CNT_LO, 32'h0);
    rdc(ADDR_CNT_HI, 32'h0);
    wr(ADDR_MOD_HI, 8'h00);
    wr(ADDR_MOD_LO, 8'h02);
    wr(ADDR_MATCH_CTRL, 8'hC0);
    wr(ADDR_SRC_PS, 8'h81);
    for (int i = 0; i < 6; i++) begin
      xfer(ADDR_CNT_LO, 1'b0, 8'h00, a);
      chk({31'h0, a <= 32'h2}, 32'h1);
    end
    rdc(ADDR_MATCH_CTRL, 32'hC0);
    chk({31'h0, match_irq}, 32'h1);
    wr(ADDR_SRC_PS, 8'h80);
    wr(ADDR_MATCH_CTRL, 8'h40);
    rdc(ADDR_MATCH_CTRL, 32'hC0);
    wr(ADDR_MATCH_CTRL, 8'hC0);
    rdc(ADDR_MATCH_CTRL, 32'h40);
    chk({31'h0, match_irq}, 32'h0);
    wr(ADDR_MOD_LO, 8'h00);
    wr(ADDR_SRC_PS, 8'h86);
    repeat (100) @(posedge clk_sys);
    rdc(ADDR_CNT_LO, 32'h0);
    rdc(ADDR_MATCH_CTRL, 32'hC0);
    results();
  end

endmodule : rpm_top_test

bind rpm_top rpm_top_asserts i_rpm_top_asserts (.clk_sys(clk_sys),
  .nrst(nrst), .ahb_req(ahb_req), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .match_irq(match_irq));

`default_nettype wire
